/* File: hw/comparator_mask_and_filter.v */
// The implementer's own choices: the address map and the APB slave port.
`timescale 1ns/1ns
`include "cmp_filter_consts.vh"

module comparator_mask_and_filter (
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [7:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output wire pready,
  output wire pslverr,
  input wire comparator_raw,
  input wire mask_source_a,
  input wire mask_source_b,
  input wire mask_source_c,
  input wire timer_four_clock,
  input wire timer_three_clock,
  input wire timer_two_clock,
  input wire pwm_sync_output_one,
  input wire oscillator_clock,
  output reg comparator_output,
  output reg blank_active
);

  // register storage
  reg [15:0] comparator_mask_gating_control;
  reg [15:0] comparator_filter_control;

  // pin synchronisers: first stage is read only by the second
  reg [3:0] pin_meta;
  reg [3:0] pin_sync;

  // gating network
  reg and_gate_result;
  reg any_and_input;
  reg next_blank;

  // blanking hold
  reg held_level;
  wire masked_level;
  wire filtered_level;
  wire filter_tick;

  // bus decode
  wire setup_phase;
  wire access_phase;
  wire write_strobe;
  wire hit_mask;
  wire hit_filter;
  wire hit_status;
  wire addr_valid;
  reg [31:0] next_prdata;

  // field views
  wire and_out_to_or_enable;
  wire and_out_inv_to_or_enable;
  wire and_in_c_enable;
  wire and_in_c_inv_enable;
  wire and_in_b_enable;
  wire and_in_b_inv_enable;
  wire and_in_a_enable;
  wire and_in_a_inv_enable;
  wire [2:0] filter_clock_select;
  wire filter_enable;
  wire [2:0] filter_clock_divide;
  wire sync_a;
  wire sync_b;
  wire sync_c;
  wire sync_cmp;

  // one source into the AND gate; both polarities at once force the term low
  function gate_term;
    input src;
    input true_en;
    input inv_en;
    begin
      gate_term = (~true_en | src) & (~inv_en | ~src);
    end
  endfunction

  // word address compare, low two bits ignored for aligned words
  function addr_is;
    input [7:0] addr;
    input [7:0] ofs;
    begin
      addr_is = (addr[7:2] == ofs[7:2]);
    end
  endfunction

  // synchronisers
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_meta <= 4'h0;
      pin_sync <= 4'h0;
    end else begin
      pin_meta <= {comparator_raw, mask_source_c, mask_source_b, mask_source_a};
      pin_sync <= pin_meta;
    end
  end

  assign sync_a = pin_sync[0];
  assign sync_b = pin_sync[1];
  assign sync_c = pin_sync[2];
  assign sync_cmp = pin_sync[3];

  // register fields as named enables
  assign and_out_to_or_enable = comparator_mask_gating_control[`MSK_AND_OUT];
  assign and_out_inv_to_or_enable = comparator_mask_gating_control[`MSK_AND_OUT_INV];
  assign and_in_c_enable = comparator_mask_gating_control[`MSK_AND_IN_C];
  assign and_in_c_inv_enable = comparator_mask_gating_control[`MSK_AND_IN_C_INV];
  assign and_in_b_enable = comparator_mask_gating_control[`MSK_AND_IN_B];
  assign and_in_b_inv_enable = comparator_mask_gating_control[`MSK_AND_IN_B_INV];
  assign and_in_a_enable = comparator_mask_gating_control[`MSK_AND_IN_A];
  assign and_in_a_inv_enable = comparator_mask_gating_control[`MSK_AND_IN_A_INV];

  assign filter_clock_select = comparator_filter_control[`FLT_SEL_HI:`FLT_SEL_LO];
  assign filter_enable = comparator_filter_control[`FLT_ENABLE];
  assign filter_clock_divide = comparator_filter_control[`FLT_DIV_HI:`FLT_DIV_LO];

  // AND/OR gating network
  // an AND gate with no input connected reads low, so an empty mask blanks only when the inverted AND output is routed to the OR
  always @* begin
    any_and_input = and_in_a_enable | and_in_a_inv_enable |
                    and_in_b_enable | and_in_b_inv_enable |
                    and_in_c_enable | and_in_c_inv_enable;
    and_gate_result = any_and_input;
    and_gate_result = and_gate_result & gate_term(sync_c, and_in_c_enable, 1'b0);
    and_gate_result = and_gate_result & gate_term(sync_c, 1'b0, and_in_c_inv_enable);
    and_gate_result = and_gate_result & gate_term(sync_b, and_in_b_enable, 1'b0);
    and_gate_result = and_gate_result & gate_term(sync_b, 1'b0, and_in_b_inv_enable);
    and_gate_result = and_gate_result & gate_term(sync_a, and_in_a_enable, 1'b0);
    and_gate_result = and_gate_result & gate_term(sync_a, 1'b0, and_in_a_inv_enable);
    next_blank = 1'b0;
    if (and_out_to_or_enable) begin
      next_blank = next_blank | and_gate_result;
    end
    if (and_out_inv_to_or_enable) begin
      next_blank = next_blank | ~and_gate_result;
    end
  end

  // blanking
  // while blanked the comparator level is frozen at its last unblanked value
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      blank_active <= 1'b0;
      held_level <= 1'b0;
    end else begin
      blank_active <= next_blank;
      if (!next_blank) begin
        held_level <= sync_cmp;
      end
    end
  end

  assign masked_level = next_blank ? held_level : sync_cmp;

  // filter clock and filter
  filter_clock_divider u_divider (
    .pclk(pclk),
    .presetn(presetn),
    .filter_clock_select(filter_clock_select),
    .filter_clock_divide(filter_clock_divide),
    .timer_four_clock(timer_four_clock),
    .timer_three_clock(timer_three_clock),
    .timer_two_clock(timer_two_clock),
    .pwm_sync_output_one(pwm_sync_output_one),
    .oscillator_clock(oscillator_clock),
    .filter_tick(filter_tick)
  );

  comparator_digital_filter u_filter (
    .pclk(pclk),
    .presetn(presetn),
    .filter_enable(filter_enable),
    .filter_tick(filter_tick),
    .sample_in(masked_level),
    .filtered_out(filtered_level)
  );

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      comparator_output <= 1'b0;
    end else begin
      comparator_output <= filtered_level;
    end
  end

  // APB slave
  // zero wait states: read data is captured in the setup cycle
  assign setup_phase = psel & ~penable;
  assign access_phase = psel & penable;
  assign hit_mask = addr_is(paddr, `OFS_MASK_GATING);
  assign hit_filter = addr_is(paddr, `OFS_FILTER_CTRL);
  assign hit_status = addr_is(paddr, `OFS_STATUS);
  assign addr_valid = hit_mask | hit_filter | (hit_status & ~pwrite);
  assign pready = 1'b1;
  assign pslverr = access_phase & ~addr_valid;
  assign write_strobe = access_phase & pwrite & addr_valid;

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      comparator_mask_gating_control <= `RST_MASK_GATING;
      comparator_filter_control <= `RST_FILTER_CTRL;
    end else if (write_strobe) begin
      if (hit_mask) begin
        comparator_mask_gating_control <= pwdata[15:0] & `MSK_WRITE_MASK;
      end
      if (hit_filter) begin
        comparator_filter_control <= pwdata[15:0] & `FLT_WRITE_MASK;
      end
    end
  end

  always @* begin
    next_prdata = 32'h0000_0000;
    if (hit_mask) begin
      next_prdata[15:0] = comparator_mask_gating_control;
    end else if (hit_filter) begin
      next_prdata[15:0] = comparator_filter_control;
    end else if (hit_status) begin
      next_prdata[`STS_RAW] = sync_cmp;
      next_prdata[`STS_MASKED] = masked_level;
      next_prdata[`STS_FILTERED] = filtered_level;
      next_prdata[`STS_BLANK] = blank_active;
      next_prdata[`STS_AND_RESULT] = and_gate_result;
    end
  end

  // status is a snapshot taken one cycle before the access phase
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else if (setup_phase) begin
      prdata <= pwrite ? 32'h0000_0000 : next_prdata;
    end
  end

endmodule

/* File: hw/cmp_filter_consts.vh */
`ifndef CMP_FILTER_CONSTS_VH
`define CMP_FILTER_CONSTS_VH

// register byte addresses
`define OFS_MASK_GATING 8'h00
`define OFS_FILTER_CTRL 8'h04
`define OFS_STATUS 8'h08

// reset values
`define RST_MASK_GATING 16'h0000
`define RST_FILTER_CTRL 16'h0000

// mask gating control fields
`define MSK_AND_IN_A_INV 0
`define MSK_AND_IN_A 1
`define MSK_AND_IN_B_INV 2
`define MSK_AND_IN_B 3
`define MSK_AND_IN_C_INV 4
`define MSK_AND_IN_C 5
`define MSK_AND_OUT 6
`define MSK_AND_OUT_INV 7
`define MSK_UNUSED_BIT 14
`define MSK_WRITE_MASK 16'hBFFF

// filter control fields
`define FLT_DIV_LO 0
`define FLT_DIV_HI 2
`define FLT_ENABLE 3
`define FLT_SEL_LO 4
`define FLT_SEL_HI 6
`define FLT_WRITE_MASK 16'h007F

// filter clock source codes
`define SRC_PERIPHERAL 3'h0
`define SRC_OSCILLATOR 3'h1
`define SRC_PWM_SYNC 3'h2
`define SRC_RESERVED 3'h3
`define SRC_TIMER_TWO 3'h4
`define SRC_TIMER_THREE 3'h5
`define SRC_TIMER_FOUR 3'h6

// status register fields
`define STS_RAW 0
`define STS_MASKED 1
`define STS_FILTERED 2
`define STS_BLANK 3
`define STS_AND_RESULT 4

// filter settles after this many agreeing samples
`define FILTER_SAMPLES 3

`endif

/* File: hw/filter_clock_divider.v */
`timescale 1ns/1ns
`include "cmp_filter_consts.vh"

module filter_clock_divider (
  input wire pclk,
  input wire presetn,
  input wire [2:0] filter_clock_select,
  input wire [2:0] filter_clock_divide,
  input wire timer_four_clock,
  input wire timer_three_clock,
  input wire timer_two_clock,
  input wire pwm_sync_output_one,
  input wire oscillator_clock,
  output reg filter_tick
);

  // two stages per pin, a third stage only for edge detection
  reg [4:0] sync_a;
  reg [4:0] sync_b;
  reg [4:0] sync_c;
  reg src_tick;
  reg [6:0] count;
  wire [6:0] limit;

  // oscillator clock faster than pclk/2 is undersampled; timer sources are expected slower
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync_a <= 5'h00;
      sync_b <= 5'h00;
      sync_c <= 5'h00;
    end else begin
      sync_a <= {oscillator_clock, pwm_sync_output_one, timer_two_clock, timer_three_clock, timer_four_clock};
      sync_b <= sync_a;
      sync_c <= sync_b;
    end
  end

  function [6:0] div_limit;
    input [2:0] code;
    begin
      div_limit = (7'h01 << code) - 7'h01;
    end
  endfunction

  assign limit = div_limit(filter_clock_divide);

  always @* begin
    case (filter_clock_select)
      `SRC_PERIPHERAL: src_tick = 1'b1;
      `SRC_OSCILLATOR: src_tick = sync_b[4] & ~sync_c[4];
      `SRC_PWM_SYNC: src_tick = sync_b[3] & ~sync_c[3];
      `SRC_TIMER_TWO: src_tick = sync_b[2] & ~sync_c[2];
      `SRC_TIMER_THREE: src_tick = sync_b[1] & ~sync_c[1];
      `SRC_TIMER_FOUR: src_tick = sync_b[0] & ~sync_c[0];
      default: src_tick = 1'b0;
    endcase
  end

  // >= keeps the divider from stalling when the ratio shrinks mid count
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      count <= 7'h00;
      filter_tick <= 1'b0;
    end else begin
      filter_tick <= 1'b0;
      if (src_tick) begin
        if (count >= limit) begin
          count <= 7'h00;
          filter_tick <= 1'b1;
        end else begin
          count <= count + 7'h01;
        end
      end
    end
  end

endmodule

/* File: hw/comparator_digital_filter.v */
`timescale 1ns/1ns
`include "cmp_filter_consts.vh"

module comparator_digital_filter (
  input wire pclk,
  input wire presetn,
  input wire filter_enable,
  input wire filter_tick,
  input wire sample_in,
  output reg filtered_out
);

  reg [`FILTER_SAMPLES-1:0] history;
  wire all_high;
  wire all_low;

  assign all_high = &history;
  assign all_low = ~(|history);

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      history <= {`FILTER_SAMPLES{1'b0}};
      filtered_out <= 1'b0;
    end else if (!filter_enable) begin
      // bypass; history tracks input so re-enabling causes no glitch
      history <= {`FILTER_SAMPLES{sample_in}};
      filtered_out <= sample_in;
    end else begin
      if (filter_tick) begin
        history <= {history[`FILTER_SAMPLES-2:0], sample_in};
      end
      if (all_high) begin
        filtered_out <= 1'b1;
      end else if (all_low) begin
        filtered_out <= 1'b0;
      end
    end
  end

endmodule

/* File: verification/cmp_mask_assertions.sv */
`timescale 1ns/1ns
module cmp_mask_checker (
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [7:0] paddr,
  input wire [31:0] pwdata,
  input wire pready,
  input wire pslverr,
  input wire comparator_raw,
  input wire mask_source_a,
  input wire mask_source_b,
  input wire mask_source_c,
  input wire comparator_output,
  input wire blank_active
);
  // shadow of mask byte and synced pins, aligned to the edge that loads blank_active
  reg [7:0] msk, m_q;
  reg fen;
  reg [2:0] s1, s2, p;
  wire wr = psel & penable & pwrite;
  wire [5:0] wa = paddr[7:2];
  wire g = |m_q[5:0] & (~m_q[1] | p[0]) & (~m_q[0] | ~p[0]) & (~m_q[3] | p[1]) & (~m_q[2] | ~p[1])
    & (~m_q[5] | p[2]) & (~m_q[4] | ~p[2]);
  wire quiet = ~fen & (m_q[7:6] == 2'b00);
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      msk <= 8'h00;
      m_q <= 8'h00;
      fen <= 1'b0;
      s1 <= 3'h0;
      s2 <= 3'h0;
      p <= 3'h0;
    end else begin
      if (wr && wa == 6'h00)
        msk <= pwdata[7:0];
      if (wr && wa == 6'h01)
        fen <= pwdata[3];
      s1 <= {mask_source_c, mask_source_b, mask_source_a};
      s2 <= s1;
      p <= s2;
      m_q <= msk;
    end
  end
  chk_or_true:
    assert property (@(posedge pclk) disable iff (!presetn) m_q[7:6] == 2'b01 |-> blank_active == g)
    else $error("blank differs from and result");
  chk_or_inv:
    assert property (@(posedge pclk) disable iff (!presetn) m_q[7:6] == 2'b10 |-> blank_active == !g)
    else $error("blank differs from inverted and result");
  chk_or_off:
    assert property (@(posedge pclk) disable iff (!presetn) (m_q[7:6] == 2'b00) [*2] |-> !blank_active)
    else $error("blank set with and output unrouted");
  chk_bypass_path:
    assert property (@(posedge pclk) disable iff (!presetn)
      quiet && $past(quiet, 2) && $past(quiet, 4) |-> comparator_output == $past(comparator_raw, 4))
    else $error("bypass output not raw delayed four edges");
  chk_ready_high:
    assert property (@(posedge pclk) disable iff (!presetn) psel |-> pready)
    else $error("pready low");
  chk_bad_addr:
    assert property (@(posedge pclk) disable iff (!presetn) psel && penable && wa > 6'h02 |-> pslverr)
    else $error("unmapped access not refused");
  chk_ro_status:
    assert property (@(posedge pclk) disable iff (!presetn) psel && penable && pwrite && wa == 6'h02 |-> pslverr)
    else $error("status write not refused");
  chk_good_addr:
    assert property (@(posedge pclk) disable iff (!presetn) psel && penable && wa < 6'h02 |-> !pslverr)
    else $error("mapped access refused");
endmodule

bind comparator_mask_and_filter cmp_mask_checker chk (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
  .pready, .pslverr, .comparator_raw, .mask_source_a, .mask_source_b, .mask_source_c, .comparator_output, .blank_active);

/* File: verification/cmp_far_side.sv */
`timescale 1ns/1ns
module cmp_far_side (
  input wire pclk,
  input wire [4:0] run,
  output reg comparator_raw,
  output reg mask_source_a,
  output reg mask_source_b,
  output reg mask_source_c,
  output wire timer_two_clock,
  output wire timer_three_clock,
  output wire timer_four_clock,
  output wire pwm_sync_output_one,
  output wire oscillator_clock
);
  // a source idles low while its run bit is clear, so selecting a stopped source sees no ticks at all
  reg [3:0] phase = 4'h0;
  always @(posedge pclk)
    phase <= phase + 4'h1;
  assign timer_two_clock = run[0] & phase[3];
  assign timer_three_clock = run[1] & phase[3];
  assign timer_four_clock = run[2] & phase[3];
  assign pwm_sync_output_one = run[3] & phase[3];
  assign oscillator_clock = run[4] & phase[3];
  initial {comparator_raw, mask_source_c, mask_source_b, mask_source_a} = 4'h0;
  task set_pins(input [3:0] v);
    begin
      @(posedge pclk);
      {comparator_raw, mask_source_c, mask_source_b, mask_source_a} <= v;
    end
  endtask
endmodule

/* File: verification/comparator_mask_and_filter_tb_top.sv */
`timescale 1ns/1ns
module comparator_mask_and_filter_tb_top;
  reg pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, er, lvl = 0;
  reg [7:0] paddr = 8'h00;
  reg [31:0] pwdata = 32'h0000_0000, rd;
  reg [4:0] run = 5'h00;
  wire [31:0] prdata;
  wire pready, pslverr, cmp_out, blank, raw, ma, mb, mc, t4, t3, t2, sy, osc;
  integer fail_count = 0, total_checks = 0, cycles = 0, i, k;
  reg [7:0] tbl [0:8] = '{8'h42, 8'h41, 8'h48, 8'h44, 8'h60, 8'h50, 8'h6a, 8'h8e, 8'hc0};
  reg [2:0] src [0:4] = '{3'h1, 3'h2, 3'h4, 3'h5, 3'h6};
  reg [4:0] run_for [0:4] = '{5'h10, 5'h08, 5'h01, 5'h02, 5'h04};

  comparator_mask_and_filter dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .comparator_raw(raw),
    .mask_source_a(ma), .mask_source_b(mb), .mask_source_c(mc), .timer_four_clock(t4), .timer_three_clock(t3),
    .timer_two_clock(t2), .pwm_sync_output_one(sy), .oscillator_clock(osc), .comparator_output(cmp_out),
    .blank_active(blank));
  cmp_far_side far (.pclk(pclk), .run(run), .comparator_raw(raw), .mask_source_a(ma), .mask_source_b(mb),
    .mask_source_c(mc), .timer_two_clock(t2), .timer_three_clock(t3), .timer_four_clock(t4),
    .pwm_sync_output_one(sy), .oscillator_clock(osc));

  initial begin
    forever #5 pclk = ~pclk;
  end

  task end_of_test;
    begin
      if (fail_count == 0 && total_checks > 0)
        $display("Run complete: PASS");
      else
        $display("Run complete: FAIL");
      $finish;
    end
  endtask

  always @(posedge pclk) begin
    cycles <= cycles + 1;
    if (cycles == 6000) begin
      fail_count = fail_count + 1;
      end_of_test;
    end
  end

  task check(input [31:0] seen, input [31:0] exp, input [63:0] what);
    begin
      total_checks = total_checks + 1;
      if (seen !== exp) begin
        $display("unexpected %0s expected %h seen %h", what, exp, seen);
        fail_count = fail_count + 1;
      end
    end
  endtask

  task apb(input w, input [7:0] a, input [31:0] d);
    begin
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1)
        @(posedge pclk);
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
    end
  endtask

  function exp_blank(input [7:0] m, input [2:0] v);
    reg g;
    begin
      g = |m[5:0] & (~m[1] | v[0]) & (~m[0] | ~v[0]) & (~m[3] | v[1]) & (~m[2] | ~v[1]) & (~m[5] | v[2])
        & (~m[4] | ~v[2]);
      exp_blank = (m[6] & g) | (m[7] & ~g);
    end
  endfunction

  task test_regs;
    begin
      apb(0, 8'h00, 32'h0000_0000);
      check(rd, 32'h0000_0000, "mask0");
      apb(0, 8'h04, 32'h0000_0000);
      check(rd, 32'h0000_0000, "filt0");
      apb(1, 8'h00, 32'hffff_ffff);
      apb(0, 8'h00, 32'h0000_0000);
      check(rd, 32'h0000_bfff, "mask");
      apb(1, 8'h04, 32'hffff_ffff);
      apb(0, 8'h04, 32'h0000_0000);
      check(rd, 32'h0000_007f, "filt");
      apb(1, 8'h08, 32'h0000_0000);
      check(er, 1, "roerr");
      apb(0, 8'h0c, 32'h0000_0000);
      check(er, 1, "unmap");
      check(rd, 32'h0000_0000, "unmapd");
      apb(1, 8'h00, 32'h0000_0000);
      apb(1, 8'h04, 32'h0000_0000);
    end
  endtask

  task test_gating;
    begin
      for (i = 0; i < 9; i = i + 1) begin
        apb(1, 8'h00, {24'h00_0000, tbl[i]});
        for (k = 0; k < 8; k = k + 1) begin
          far.set_pins({1'b0, k[2:0]});
          repeat (4) @(posedge pclk);
          check(blank, exp_blank(tbl[i], k[2:0]), "blank");
        end
      end
      apb(0, 8'h08, 32'h0000_0000);
      check(rd, 32'h0000_0008, "stsblk");
      apb(1, 8'h00, 32'h0000_0000);
      far.set_pins(4'h0);
    end
  endtask

  task test_bypass;
    begin
      far.set_pins(4'h8);
      repeat (3) @(posedge pclk);
      check(cmp_out, 0, "early");
      repeat (2) @(posedge pclk);
      check(cmp_out, 1, "bypass");
      apb(0, 8'h08, 32'h0000_0000);
      check(rd, 32'h0000_0007, "status");
      far.set_pins(4'h0);
      repeat (6) @(posedge pclk);
    end
  endtask

  // three agreeing samples: a change takes two to three tick periods to show
  task step(input integer hold, input integer lim, input moves);
    begin
      lvl = ~lvl;
      far.set_pins({lvl, 3'h0});
      repeat (hold) @(posedge pclk);
      check(cmp_out, !lvl, "held");
      repeat (lim - hold) @(posedge pclk);
      check(cmp_out, moves ? lvl : !lvl, "settled");
    end
  endtask

  task test_filter;
    begin
      for (i = 0; i < 5; i = i + 1) begin
        apb(1, 8'h04, {25'h000_0000, src[i], 4'h8});
        run <= run_for[i];
        repeat (40) @(posedge pclk);
        step(20, 80, 1);
      end
      apb(1, 8'h04, 32'h0000_000c);
      repeat (40) @(posedge pclk);
      step(20, 80, 1);
      apb(1, 8'h04, 32'h0000_000e);
      repeat (40) @(posedge pclk);
      step(100, 230, 1);
      apb(1, 8'h04, 32'h0000_000f);
      repeat (40) @(posedge pclk);
      step(200, 450, 1);
      run <= 5'h1f;
      apb(1, 8'h04, 32'h0000_0038);
      repeat (40) @(posedge pclk);
      step(300, 300, 0);
      lvl = ~lvl;
      far.set_pins({lvl, 3'h0});
    end
  endtask

  initial begin
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    test_regs;
    test_gating;
    test_bypass;
    test_filter;
    end_of_test;
  end
endmodule
